// file: hw/acf_timing_pkg.sv
/*
 * constants for the active-clamp flyback timing core: register map, field
 * positions, reset values, state encoding and all timing counts.
 * assumes a single 10 mhz core clock; every time below is turned into cycles here.
 */
package acf_timing_pkg;

	// ------------------------------------------------------------
	// clock
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 100000; // 10 mhz core clock

	// ------------------------------------------------------------
	// documented times, in their own units
	// ------------------------------------------------------------
	localparam int unsigned WAKE_TIME_NS = 2200; // 2.2 us driver wake-up
	localparam int unsigned ZC_TIMEOUT_NS = 2200; // 2.2 us zero-cross time-out
	localparam int unsigned LH_DEAD_FIXED_NS = 40; // fixed low-to-high dead time
	localparam int unsigned ZC_TO_HIGH_NS = 50; // zero-cross to high-side delay
	localparam int unsigned BLANK_LOW_NS = 130; // sense blanking, strap low
	localparam int unsigned BLANK_HIGH_NS = 200; // sense blanking, strap high
	localparam int unsigned MIN_ON_LOW_NS = 65; // min low-side on time, strap low
	localparam int unsigned MIN_ON_HIGH_NS = 90; // min low-side on time, strap high

	// least times round up, longest times round down, never below one cycle
	function automatic int unsigned cyc_up(input int unsigned ns);
		int unsigned c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	function automatic int unsigned cyc_dn(input int unsigned ns);
		int unsigned c;
		c = (ns * 1000) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [7:0] WAKE_CYC = 8'(cyc_up(WAKE_TIME_NS));
	localparam logic [7:0] ZC_TIMEOUT_CYC = 8'(cyc_dn(ZC_TIMEOUT_NS));
	localparam logic [7:0] LH_DEAD_FIXED_CYC = 8'(cyc_up(LH_DEAD_FIXED_NS));
	localparam logic [7:0] ZC_TO_HIGH_CYC = 8'(cyc_up(ZC_TO_HIGH_NS));
	localparam logic [7:0] BLANK_LOW_CYC = 8'(cyc_up(BLANK_LOW_NS));
	localparam logic [7:0] BLANK_HIGH_CYC = 8'(cyc_up(BLANK_HIGH_NS));
	localparam logic [7:0] MIN_ON_LOW_CYC = 8'(cyc_up(MIN_ON_LOW_NS));
	localparam logic [7:0] MIN_ON_HIGH_CYC = 8'(cyc_up(MIN_ON_HIGH_NS));

	// ------------------------------------------------------------
	// tuning and line feed-forward
	// ------------------------------------------------------------
	localparam logic [9:0] LINE_KNEE_UA = 10'd666; // extension starts below this
	localparam logic [4:0] TZ_EXT_NUM = 5'd14; // full extension is 14/10 of minimum
	localparam logic [13:0] TZ_EXT_DEN = 14'd6660; // 10 x knee current
	localparam logic [3:0] SETTLE_CYCLES = 4'd15; // loop settled by this many cycles
	localparam logic [7:0] COARSE_STEP = 8'h04; // demag step before settling
	localparam logic [7:0] FINE_STEP = 8'h01; // one lsb after settling
	localparam logic [7:0] DEMAG_RESET = 8'h02; // short start: valley switching

	// ------------------------------------------------------------
	// register map (byte addresses) and fields
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] TIMING_ADDR = 4'h4;
	localparam logic [3:0] STATUS_ADDR = 4'h8;
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_MODE_LSB = 1; // 2-bit operating mode
	localparam int unsigned CTRL_PULSES_LSB = 4; // 4-bit pulses per packet
	localparam int unsigned CTRL_IDLE_LSB = 8; // 8-bit burst idle cycles
	localparam int unsigned TIMING_ONMAX_LSB = 0; // 8-bit low-side on-time cap
	localparam int unsigned TIMING_TZMIN_LSB = 8; // 8-bit minimum falling wait
	localparam logic [31:0] CTRL_RESET = 32'h0000_2040;
	localparam logic [31:0] TIMING_RESET = 32'h0000_0414;

	typedef enum logic [1:0] {MODE_AAM, MODE_ABM, MODE_LPM, MODE_SBP} op_mode_t;

	typedef enum {
		ST_IDLE, ST_WAKE, ST_ZC_WAIT, ST_LOW_ON, ST_LH_DEAD, ST_HIGH_ON, ST_TZ_WAIT, ST_VALLEY
	} phase_t;

endpackage

// file: hw/acf_zvs_deadtime_timing.sv
/*
 * timing core of an active-clamp flyback controller: low/high gate commands,
 * driver enable, burst wake-up and zero-cross wait, dead times, sense blanking,
 * demag interval auto-tuning and line feed-forward on the falling wait.
 * assumes all inputs synchronous to core_clk, comparators already digitised,
 * and a simple strobe register port with read data one cycle later.
 */
//
// Contract
// - driver enable high whenever driver must run
// - driver enable low between burst packets
// - wait 2.2 us after enable rises
// - first low pulse on zero-cross or 2.2 us
// - strap picks 4 V or 9 V target
// - strap low: 40 ns dead, high: adaptive
// - blank sense 130 or 200 ns
// - low-power modes: min on 65/90 ns
// - auto-tune high on-time via demag interval
// - node still high: lengthen demag next cycle
// - settled loop steps one lsb per cycle
// - settle within 15 cycles then toggle lsb
// - low line current extends wait to 140%; code adds up to 140% of the minimum, so the wait reaches 240%
// - sample line info only while low on
// - adaptive: high on 50 ns after zero-cross
// - falling wait is high-fall to low-rise
`timescale 1ns/1ps

module acf_zvs_deadtime_timing
	import acf_timing_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en, // low freezes all state
	input wire logic stage_select, // strap, caught once after reset
	input wire logic zero_cross_detect, // aux winding zero crossing
	input wire logic switch_node_sense, // high: node still above target
	input wire logic cs_trip, // current-sense peak comparator
	input wire logic [9:0] line_sense_current, // line current in ua
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic low_side_gate_cmd,
	output logic high_side_gate_cmd,
	output logic driver_enable,
	output logic soft_switch_target, // high selects the 9 v target
	output logic sense_blank // high while the cs compare is masked
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [31:0] ctrl_q; // enable, mode, packet size, idle time
	logic [31:0] timing_q; // on-time cap, minimum falling wait
	logic [31:0] rdata_q; // read data, valid one cycle after strobe
	logic strap_q; // caught stage select
	logic strap_taken_q; // strap sampled after release
	phase_t phase_q, phase_d; // sequencer state
	logic [7:0] cnt_q; // per-phase cycle timer
	logic [3:0] pulse_q; // low pulses in this packet
	logic [7:0] demag_q; // synthesised demag interval, cycles
	logic [3:0] tune_cyc_q; // switching cycles since tuning began
	logic settled_q; // tuning loop locked
	logic last_up_q; // direction of previous step
	logic [9:0] line_q; // line current held from the low-side on phase
	logic [9:0] tz_q; // falling wait in use
	logic low_d, high_d; // next gate commands
	logic run_d; // next driver enable
	logic low_q, high_q, run_q, blank_q;
	op_mode_t mode;
	logic high_allowed; // high side runs only in aam and abm
	logic burst;
	logic [7:0] blank_cyc, min_on_cyc;
	logic blank_done, min_on_done, on_max_done;
	logic tz_done;

	assign mode = op_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
	assign high_allowed = (mode == MODE_AAM) || (mode == MODE_ABM);
	assign burst = (mode != MODE_AAM);
	assign blank_cyc = strap_q ? BLANK_HIGH_CYC : BLANK_LOW_CYC;
	assign min_on_cyc = high_allowed ? 8'h01 : (strap_q ? MIN_ON_HIGH_CYC : MIN_ON_LOW_CYC);
	assign blank_done = (cnt_q >= blank_cyc);
	assign min_on_done = (cnt_q >= min_on_cyc);
	assign on_max_done = (cnt_q >= timing_q[TIMING_ONMAX_LSB +: 8]);
	assign tz_done = ({2'b00, cnt_q} >= tz_q);

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------

	// software writes: control and timing words
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			timing_q <= TIMING_RESET;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == CTRL_ADDR) begin
				ctrl_q <= {16'h0000, reg_wdata[15:0]};
			end else if (reg_addr == TIMING_ADDR) begin
				timing_q <= {16'h0000, reg_wdata[15:0]};
			end
		end
	end

	// reads: one-cycle latency, unmapped addresses read zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			if (reg_rd) begin
				unique case (reg_addr)
					CTRL_ADDR: rdata_q <= ctrl_q;
					TIMING_ADDR: rdata_q <= timing_q;
					// 6 + 10 + 8 + 4 + 4 bits: fields sit exactly at their mapped positions
					STATUS_ADDR: rdata_q <= {6'h00, tz_q, demag_q, pulse_q, settled_q, strap_q, high_q, run_q};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end else begin
				rdata_q <= 32'h0000_0000; // data stands only in the cycle after the strobe
			end
		end
	end

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------

	// caught on the first enabled edge after reset; fixed afterwards so the
	// blanking and dead-time choice cannot change in the middle of a packet
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			strap_q <= 1'b0;
			strap_taken_q <= 1'b0;
		end else if (clk_en && !strap_taken_q) begin
			strap_q <= stage_select;
			strap_taken_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// line feed-forward on the falling wait
	// ------------------------------------------------------------

	// line information is only meaningful with the low side on
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			line_q <= LINE_KNEE_UA;
		end else if (clk_en && phase_q == ST_LOW_ON) begin
			line_q <= line_sense_current;
		end
	end

	// tz = tz_min + tz_min * 1.4 * (knee - i) / knee below the knee
	always_ff @(posedge core_clk or posedge rst) begin
		logic [9:0] diff;
		logic [22:0] prod;
		if (rst) begin
			tz_q <= 10'h000;
		end else if (clk_en) begin
			diff = (line_q < LINE_KNEE_UA) ? 10'(LINE_KNEE_UA - line_q) : 10'h000;
			prod = 23'(timing_q[TIMING_TZMIN_LSB +: 8]) * 23'(diff) * 23'(TZ_EXT_NUM);
			tz_q <= 10'(timing_q[TIMING_TZMIN_LSB +: 8]) + 10'(prod / 23'(TZ_EXT_DEN));
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------

	// next phase; each phase owns at most one gate, so no path lets both rise
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			ST_IDLE: begin
				// in burst the idle gap is the packet off-time with the driver asleep
				if (ctrl_q[CTRL_ENABLE_BIT] && (!burst || cnt_q >= ctrl_q[CTRL_IDLE_LSB +: 8])) begin
					phase_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (cnt_q >= WAKE_CYC - 8'h01) begin
					phase_d = ST_ZC_WAIT;
				end
			end
			ST_ZC_WAIT: begin
				if (zero_cross_detect || cnt_q >= ZC_TIMEOUT_CYC - 8'h01) begin
					phase_d = ST_LOW_ON;
				end
			end
			ST_LOW_ON: begin
				// peak trip ignored inside blanking and before the minimum on-time
				if (on_max_done || (cs_trip && blank_done && min_on_done)) begin
					phase_d = high_allowed ? ST_LH_DEAD : ST_VALLEY;
				end
			end
			ST_LH_DEAD: begin
				if (!strap_q) begin
					if (cnt_q >= LH_DEAD_FIXED_CYC - 8'h01) begin
						phase_d = ST_HIGH_ON;
					end
				end else if (cnt_q >= ZC_TIMEOUT_CYC - 8'h01) begin
					phase_d = ST_HIGH_ON; // no edge seen: do not stall the cycle
				end else if (zero_cross_detect) begin
					phase_d = ST_HIGH_ON; // one cycle covers the 50 ns delay
				end
			end
			ST_HIGH_ON: begin
				if (cnt_q >= demag_q - 8'h01) begin
					phase_d = ST_TZ_WAIT;
				end
			end
			ST_TZ_WAIT: begin
				if (tz_done) begin
					phase_d = ST_LOW_ON;
				end
			end
			ST_VALLEY: begin
				if (zero_cross_detect || cnt_q >= ZC_TIMEOUT_CYC - 8'h01) begin
					phase_d = ST_LOW_ON;
				end
			end
		endcase
		// packet complete, or disabled: drop the driver and go idle
		if ((phase_d == ST_LOW_ON) && (phase_q != ST_LOW_ON) && burst
				&& (pulse_q >= ctrl_q[CTRL_PULSES_LSB +: 4]) && (phase_q != ST_ZC_WAIT)) begin
			phase_d = ST_IDLE;
		end
		if (!ctrl_q[CTRL_ENABLE_BIT]) begin
			phase_d = ST_IDLE;
		end
	end

	// gate and enable outputs follow the next phase
	always_comb begin
		low_d = (phase_d == ST_LOW_ON);
		high_d = (phase_d == ST_HIGH_ON) && !low_d;
		run_d = (phase_d != ST_IDLE);
	end

	// phase register, timer and registered outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_q <= ST_IDLE;
			cnt_q <= 8'h00;
			low_q <= 1'b0;
			high_q <= 1'b0;
			run_q <= 1'b0;
			blank_q <= 1'b0;
		end else if (clk_en) begin
			phase_q <= phase_d;
			if (phase_d != phase_q) begin
				cnt_q <= 8'h00;
			end else if (cnt_q != 8'hff) begin
				cnt_q <= cnt_q + 8'h01;
			end
			low_q <= low_d;
			high_q <= high_d;
			run_q <= run_d;
			// blank from the low-side rise for the strap-selected count
			blank_q <= low_d && ((phase_d != phase_q) || (cnt_q + 8'h01 < blank_cyc));
		end
	end

	// pulses per packet, counted at each low-side rise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pulse_q <= 4'h0;
		end else if (clk_en) begin
			if (phase_d == ST_IDLE) begin
				pulse_q <= 4'h0;
			end else if (phase_d == ST_LOW_ON && phase_q != ST_LOW_ON && pulse_q != 4'hf) begin
				pulse_q <= pulse_q + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// demag interval tuning
	// ------------------------------------------------------------

	// judged when the falling wait expires; coarse steps until settled, then
	// one lsb a cycle so steady state only dithers around the target
	always_ff @(posedge core_clk or posedge rst) begin
		logic [7:0] step;
		if (rst) begin
			demag_q <= DEMAG_RESET;
			tune_cyc_q <= 4'h0;
			settled_q <= 1'b0;
			last_up_q <= 1'b1;
		end else if (clk_en) begin
			step = settled_q ? FINE_STEP : COARSE_STEP;
			if (!high_allowed) begin
				tune_cyc_q <= 4'h0; // valley switching: loop parked
				settled_q <= 1'b0;
			end else if (phase_q == ST_TZ_WAIT && tz_done) begin
				if (switch_node_sense) begin
					demag_q <= (demag_q > 8'hff - step) ? 8'hff : demag_q + step;
					last_up_q <= 1'b1;
				end else begin
					demag_q <= (demag_q > step) ? demag_q - step : 8'h01;
					last_up_q <= 1'b0;
				end
				if (tune_cyc_q != 4'hf) begin
					tune_cyc_q <= tune_cyc_q + 4'h1;
				end
				// settle on first reversal, and never later than the cycle bound
				if ((last_up_q != switch_node_sense) || (tune_cyc_q >= SETTLE_CYCLES - 4'h2)) begin
					settled_q <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata = rdata_q;
	assign low_side_gate_cmd = low_q;
	assign high_side_gate_cmd = high_q;
	assign driver_enable = run_q;
	assign soft_switch_target = strap_q;
	assign sense_blank = blank_q;

endmodule

// file: test/acf_stage_model.sv
/*
 * model of the gate driver and power stage seen from the timing core.
 * assumes gate commands and driver enable change just after core_clk edges.
 */
`timescale 1ns/1ps

module acf_stage_model #(
	parameter int ON_LEN = 4, // cycles from low gate rise to the current peak
	parameter int NEED = 9 // high-side on time that pulls the node below target
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic low_side_gate_cmd,
	input wire logic high_side_gate_cmd,
	input wire logic driver_enable,
	output logic zero_cross_detect,
	output logic switch_node_sense,
	output logic cs_trip
);
	int on_cnt, off_cnt, hi_cnt, last_w; // phase counters and last high width

	// --------
	// stage state
	// --------
	// a short clamp pulse leaves the node high, so tuning must really move
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			on_cnt <= 0;
			off_cnt <= 0;
			hi_cnt <= 0;
			last_w <= 0;
		end else begin
			on_cnt <= low_side_gate_cmd ? on_cnt + 1 : 0;
			off_cnt <= (low_side_gate_cmd || high_side_gate_cmd || !driver_enable) ? 0 : off_cnt + 1;
			hi_cnt <= high_side_gate_cmd ? hi_cnt + 1 : 0;
			if (!high_side_gate_cmd && hi_cnt != 0) begin
				last_w <= hi_cnt;
			end
		end
	end

	// ringing crosses zero every eight cycles while both switches are off
	assign zero_cross_detect = driver_enable && off_cnt[2:0] == 3'h3;
	assign cs_trip = low_side_gate_cmd && on_cnt >= ON_LEN - 1;
	assign switch_node_sense = last_w < NEED;
endmodule

// file: test/acf_zvs_deadtime_timing_bench.sv
/*
 * self-checking bench for the flyback timing core: registers, tuning, line
 * stretch, burst modes and strap. assumes the stage model and bound checker.
 */
`timescale 1ns/1ps

module acf_zvs_deadtime_timing_bench;
	import acf_timing_pkg::*;
	logic core_clk = 1'b0, rst = 1'b0, clk_en = 1'b1, stage_select = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic zero_cross_detect, switch_node_sense, cs_trip, low_side_gate_cmd, high_side_gate_cmd;
	logic driver_enable, soft_switch_target, sense_blank, low_q = 1'b0, en_q = 1'b0;
	logic [9:0] line_sense_current = 10'h2bc;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, ctrl_m, timing_m; // register model
	logic [15:0] lfsr = 16'h005c; // seed 92
	int bad_count = 0, checks = 0, lows = 0, pcnt = 0, hw = 0, since_high = 0, gap = 0, g0;
	int widths[$], pkts[$]; // high pulse widths, low pulses per packet

	always #50 core_clk = ~core_clk; // 10 mhz

	acf_zvs_deadtime_timing acf_zvs_deadtime_timing_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.stage_select(stage_select), .zero_cross_detect(zero_cross_detect), .switch_node_sense(switch_node_sense),
		.cs_trip(cs_trip), .line_sense_current(line_sense_current), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_side_gate_cmd(low_side_gate_cmd),
		.high_side_gate_cmd(high_side_gate_cmd), .driver_enable(driver_enable),
		.soft_switch_target(soft_switch_target), .sense_blank(sense_blank));
	acf_stage_model acf_stage_model_inst (.core_clk(core_clk), .rst(rst), .low_side_gate_cmd(low_side_gate_cmd),
		.high_side_gate_cmd(high_side_gate_cmd), .driver_enable(driver_enable),
		.zero_cross_detect(zero_cross_detect), .switch_node_sense(switch_node_sense), .cs_trip(cs_trip));

	// --------
	// helpers
	// --------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// pulse widths, falling wait and packet lengths seen at the gate pins
	always @(posedge core_clk) begin
		if (high_side_gate_cmd) begin
			hw++;
			since_high = 0;
		end else begin
			if (hw != 0) begin
				widths.push_back(hw);
			end
			hw = 0;
			since_high++;
		end
		if (low_side_gate_cmd && !low_q) begin
			lows++;
			pcnt++;
			gap = since_high;
		end
		if (!driver_enable && en_q) begin
			pkts.push_back(pcnt);
			pcnt = 0;
		end
		low_q = low_side_gate_cmd;
		en_q = driver_enable;
	end

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// writes keep the lower half only, unmapped writes vanish
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (a == CTRL_ADDR) ctrl_m = {16'h0, d[15:0]};
		if (a == TIMING_ADDR) timing_m = {16'h0, d[15:0]};
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp, input string name);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		cmp(name, exp, reg_rdata & mask);
	endtask

	// bounded wait on low pulses or finished packets
	task automatic wait_until(input int target, input bit on_pkts);
		int i;
		for (i = 0; i < 20000 && (on_pkts ? pkts.size() : lows) < target; i++)
			@(posedge core_clk);
		if (i == 20000) begin
			cmp("wait", 0, 1);
			results();
		end
	endtask

	task automatic do_reset(input logic strap);
		rst <= 1'b1;
		stage_select <= strap;
		repeat (16) @(posedge core_clk);
		cmp("reset outputs", 0, {low_side_gate_cmd, high_side_gate_cmd, driver_enable});
		rst <= 1'b0;
		ctrl_m = CTRL_RESET;
		timing_m = TIMING_RESET;
		@(posedge core_clk);
		@(negedge core_clk);
		pkts.delete();
		widths.delete();
	endtask

	// --------
	// main sequence
	// --------
	initial begin
		do_reset(1'b0);
		rd(CTRL_ADDR, '1, ctrl_m, "ctrl");
		rd(TIMING_ADDR, '1, timing_m, "timing");
		rd(STATUS_ADDR, 32'h5, 32'h0, "status run strap");
		lfsr = lfsr_next(lfsr);
		wr(TIMING_ADDR, {lfsr, 16'h0414});
		wr(4'hc, {lfsr, lfsr});
		rd(TIMING_ADDR, '1, timing_m, "timing upper");
		rd(4'hc, '1, 32'h0, "unmapped");
		$display("test registers done");
		lfsr = lfsr_next(lfsr);
		line_sense_current <= 10'd666 + 10'(lfsr % 16'd358);
		wr(CTRL_ADDR, 32'h2041);
		wait_until(24, 1'b0);
		cmp("enable drops", 0, pkts.size());
		cmp("width grows", 1, widths[1] > widths[0]);
		for (int i = 16; i < widths.size(); i++)
			cmp("settled step", 1, (widths[i] - widths[i - 1]) inside {-1, 0, 1});
		cmp("tuned width", 1, widths[$] inside {[8:10]});
		rd(STATUS_ADDR, 32'h8, 32'h8, "settled");
		g0 = gap;
		@(posedge core_clk); // inputs only move right after a rising edge
		line_sense_current <= 10'h000;
		wait_until(lows + 4, 1'b0);
		cmp("wait stretch", (4 * 14 * 666) / 6660, gap - g0);
		$display("test tuning done");
		// burst, low power and standby each in turn
		for (int m = 1; m < 4; m++) begin
			wr(CTRL_ADDR, 32'h1031 | (m << 1));
			wait_until(pkts.size() + 1, 1'b1);
			pkts.delete();
			widths.delete();
			wait_until(2, 1'b1);
			cmp("packet one", 3, pkts[0]);
			cmp("packet two", 3, pkts[1]);
			cmp("high pulses", (m == 1) ? 6 : 0, widths.size());
			$display("test mode %0d done", m);
		end
		do_reset(1'b1);
		cmp("target", 1, soft_switch_target);
		rd(STATUS_ADDR, 32'h4, 32'h4, "status strap");
		wr(CTRL_ADDR, 32'h2041);
		wait_until(lows + 10, 1'b0);
		cmp("adaptive highs", 1, widths.size() >= 8);
		wr(CTRL_ADDR, 32'h2040);
		for (int i = 0; i < 200 && driver_enable !== 1'b0; i++)
			@(posedge core_clk);
		cmp("stopped", 0, driver_enable);
		$display("test strap done");
		results();
	end
endmodule

// file: test/acf_zvs_deadtime_timing_sva.sv
/*
 * checker for the flyback timing core, bound to its top ports.
 * assumes one clock domain and an active high asynchronous reset.
 */
`timescale 1ns/1ps

module acf_timing_sva (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic zero_cross_detect,
	input wire logic low_side_gate_cmd,
	input wire logic high_side_gate_cmd,
	input wire logic driver_enable,
	input wire logic soft_switch_target,
	input wire logic sense_blank
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0] wake_cnt_q; // cycles since driver enable rose, saturating

	// --------
	// wake counter
	// --------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_cnt_q <= 8'h00;
		end else if (!driver_enable) begin
			wake_cnt_q <= 8'h00;
		end else if (wake_cnt_q != 8'hff) begin
			wake_cnt_q <= wake_cnt_q + 8'h01;
		end
	end

	gates_exclusive_a: assert property (!(low_side_gate_cmd && high_side_gate_cmd))
		else $error("both gate commands high");
	reset_quiet_a: assert property (disable iff (1'b0) rst |-> !low_side_gate_cmd && !high_side_gate_cmd && !driver_enable)
		else $error("output active in reset");
	enable_gates_a: assert property (!driver_enable |-> !low_side_gate_cmd && !high_side_gate_cmd)
		else $error("gate active with driver off");
	wake_wait_a: assert property ($rose(low_side_gate_cmd) |-> wake_cnt_q >= 8'h15)
		else $error("low pulse inside wake time");
	first_pulse_a: assert property ($rose(driver_enable) |-> ##[21:48] $rose(low_side_gate_cmd))
		else $error("first low pulse late");
	blank_window_a: assert property ($rose(low_side_gate_cmd) |-> sense_blank ##1 sense_blank ##1 !sense_blank)
		else $error("blanking length wrong");
	min_on_a: assert property ($rose(low_side_gate_cmd) |-> low_side_gate_cmd [*3])
		else $error("low pulse too short");
	fixed_dead_a: assert property ($rose(high_side_gate_cmd) && !soft_switch_target
		|-> $past(low_side_gate_cmd, 2) || $past(low_side_gate_cmd, 3))
		else $error("fixed dead time wrong");
	adaptive_dead_a: assert property ($rose(high_side_gate_cmd) && soft_switch_target
		|-> $past(zero_cross_detect) || $past(zero_cross_detect, 2))
		else $error("high gate not tied to zero cross");
	tz_gap_a: assert property ($fell(high_side_gate_cmd) |-> !low_side_gate_cmd [*3])
		else $error("falling wait too short");
	strap_hold_a: assert property ($past(driver_enable) |-> $stable(soft_switch_target))
		else $error("target moved while running");
endmodule

bind acf_zvs_deadtime_timing acf_timing_sva acf_timing_sva_inst (.core_clk(core_clk), .rst(rst),
	.zero_cross_detect(zero_cross_detect), .low_side_gate_cmd(low_side_gate_cmd),
	.high_side_gate_cmd(high_side_gate_cmd), .driver_enable(driver_enable),
	.soft_switch_target(soft_switch_target), .sense_blank(sense_blank));
